// [core/tfm_defs.svh]
// Functional notes
// - Flush-process suspends then rebinds the same process, only while executing.
// - Flush-process stops process timing and then restarts it.
// - Flush-process invalidates current block descriptor, regions 0-2 descriptors and their PTEs.
// - Flush-process outside the executing state is ignored completely.
// - Flush-whole keeps segment table, region 3, current block, regions 0-2 descriptors.
// - Flush-whole also keeps the PTE of the interrupt stack's first page.
// - Flush-PTE carries segment offset in field 3, selector in field 4.
// - Flush-PTE removes the entry of the page holding selector plus offset.
// - Flush-PTE raises a length fault when the offset equals or exceeds segment length.
// - Directory entries are never held, so flush-PTE never targets them.
// - Flush-physical-page removes every entry pointing directly at the field 3 page.
// - Includes direct pointers, paged table pages and bipaged directory pages.
// - Flush-physical-page also runs the full local-register flush.
// - If it removed current process descriptors, flush-process also runs.
// - Local flush writes all register sets back, then purges all but active.
`ifndef TFM_DEFS_SVH
`define TFM_DEFS_SVH

// ----------------------------------------
// Message types
// ----------------------------------------
`define TFM_MSG_FLUSH_PROC  8'h87
`define TFM_MSG_FLUSH_ALL   8'h8A
`define TFM_MSG_FLUSH_PTE   8'h8C
`define TFM_MSG_FLUSH_PHYS  8'h88

// ----------------------------------------
// Entry owner codes and paging kinds
// ----------------------------------------
`define TFM_OWN_OTHER       3'h0
`define TFM_OWN_SEG_TABLE   3'h1
`define TFM_OWN_REGION3     3'h2
`define TFM_OWN_PCB         3'h3
`define TFM_OWN_REGION0     3'h4
`define TFM_OWN_REGION1     3'h5
`define TFM_OWN_REGION2     3'h6
`define TFM_PAGING_SIMPLE   2'h0
`define TFM_PAGING_PAGED    2'h1
`define TFM_PAGING_BIPAGED  2'h2

// ----------------------------------------
// Address layout
// ----------------------------------------
`define TFM_PAGE_LSB        12
`define TFM_PAGE_W          20
`define TFM_DEPTH_DEFAULT   16

`endif

// [core/tfm_pkg.sv]
`include "tfm_defs.svh"
package tfm_pkg;

  typedef struct packed {
    logic [7:0]  msg_type;
    logic [31:0] field1;
    logic [31:0] field2;
    logic [31:0] field3;
    logic [31:0] field4;
    logic [31:0] field5;
  } tfm_msg_t;

  typedef struct packed {
    logic                   valid;
    logic                   is_pte;
    logic [2:0]             owner;
    logic [1:0]             paging;
    logic                   int_stack;
    logic [31:0]            sel;
    logic [`TFM_PAGE_W-1:0] vpage;
    logic [`TFM_PAGE_W-1:0] ppage;
    logic [`TFM_PAGE_W-1:0] tpage;
  } tfm_entry_t;

  typedef enum logic [1:0] {
    MODE_PROC,
    MODE_ALL,
    MODE_PTE,
    MODE_PHYS
  } tfm_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEN_WAIT,
    ST_SUSPEND,
    ST_SCAN_RD,
    ST_SCAN_CHK,
    ST_REBIND,
    ST_LREG_WB,
    ST_LREG_PURGE
  } tfm_state_t;

endpackage

// [core/tfm_tlb_mem.sv]
`timescale 1ns/1ps
`include "tfm_defs.svh"
module tfm_tlb_mem
  import tfm_pkg::*;
#(
  parameter int DEPTH = `TFM_DEPTH_DEFAULT,
  parameter int IW    = $clog2(`TFM_DEPTH_DEFAULT)
) (
  input  wire logic          clk_i,
  input  wire logic          reset_n_i,
  input  wire logic          rd_en_i,
  input  wire logic [IW-1:0] rd_addr_i,
  output tfm_entry_t         rd_data_o,
  input  wire logic          wr_en_i,
  input  wire logic [IW-1:0] wr_addr_i,
  input  wire tfm_entry_t    wr_data_i
);

  // Contents carry no reset; only fills give them meaning, since flush-whole leaves the entries it keeps untouched.
  tfm_entry_t mem_reg [DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= '0;
    end else if (rd_en_i) begin
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end

endmodule

// [core/tfm_handler.sv]
`timescale 1ns/1ps
`include "tfm_defs.svh"
module tfm_handler
  import tfm_pkg::*;
#(
  parameter int DEPTH = `TFM_DEPTH_DEFAULT,
  parameter int IW    = $clog2(`TFM_DEPTH_DEFAULT)
) (
  input  wire logic          clk_i,
  input  wire logic          reset_n_i,
  input  wire logic          msg_valid_i,
  input  wire tfm_msg_t      msg_i,
  output logic               msg_ready_o,
  input  wire logic          proc_executing_i,
  input  wire logic          fill_valid_i,
  input  wire logic [IW-1:0] fill_idx_i,
  input  wire tfm_entry_t    fill_entry_i,
  output logic               fill_ready_o,
  output logic               len_req_o,
  output logic [31:0]        len_sel_o,
  input  wire logic          len_ack_i,
  input  wire logic [31:0]   len_value_i,
  output logic               length_fault_o,
  output logic               suspend_o,
  output logic               rebind_o,
  output logic               timing_stop_o,
  output logic               timing_start_o,
  output logic               lreg_wb_req_o,
  input  wire logic          lreg_wb_done_i,
  output logic               lreg_purge_req_o,
  input  wire logic          lreg_purge_done_i
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (DEPTH < 2 || (1 << IW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two of at least 2 and IW its log2.");
  end

  // ----------------------------------------
  // Entry decode
  // ----------------------------------------
  function automatic logic tfm_proc_owned(input tfm_entry_t e);
    return e.owner == `TFM_OWN_PCB || e.owner == `TFM_OWN_REGION0 ||
           e.owner == `TFM_OWN_REGION1 || e.owner == `TFM_OWN_REGION2;
  endfunction

  function automatic logic tfm_kill(input tfm_entry_t e, input tfm_mode_t m, input tfm_msg_t g);
    logic keep_all;
    logic [`TFM_PAGE_W-1:0] pg;
    keep_all = (!e.is_pte && (tfm_proc_owned(e) || e.owner == `TFM_OWN_SEG_TABLE ||
                              e.owner == `TFM_OWN_REGION3)) ||
               (e.is_pte && e.int_stack);
    pg = g.field3[31:`TFM_PAGE_LSB];
    case (m)
      MODE_PROC: return e.valid && tfm_proc_owned(e);
      MODE_ALL:  return e.valid && !keep_all;
      // Directory entries are never loaded, so only PTEs can match here.
      MODE_PTE:  return e.valid && e.is_pte && e.sel == g.field4 && e.vpage == pg;
      MODE_PHYS: return e.valid && (e.ppage == pg ||
                        (!e.is_pte && e.paging != `TFM_PAGING_SIMPLE && e.tpage == pg));
      default:   return 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  tfm_state_t      state_reg,   state_next;
  tfm_mode_t       mode_reg,    mode_next;
  tfm_msg_t        msg_reg,     msg_next;
  logic [IW-1:0]   idx_reg,     idx_next;
  logic            hit_reg,     hit_next;
  logic            ready_reg,   ready_next;
  logic            len_req_reg, len_req_next;
  logic [31:0]     len_sel_reg, len_sel_next;
  logic            fault_reg,   fault_next;
  logic            susp_reg,    susp_next;
  logic            rebind_reg,  rebind_next;
  logic            tstop_reg,   tstop_next;
  logic            tstart_reg,  tstart_next;
  logic            wb_reg,      wb_next;
  logic            purge_reg,   purge_next;

  tfm_entry_t      rd_data;
  logic            scan_wr;
  tfm_entry_t      dead_entry;

  wire logic       accept_w  = msg_valid_i && ready_reg;
  wire logic       fill_w    = fill_valid_i && ready_reg;
  wire logic       last_w    = idx_reg == IW'(DEPTH - 1);
  wire logic       kill_w    = tfm_kill(rd_data, mode_reg, msg_reg);
  wire logic       rd_en_w   = state_reg == ST_SCAN_RD;
  wire logic       mem_we_w  = scan_wr || fill_w;
  wire logic [IW-1:0] wr_addr_w = scan_wr ? idx_reg : fill_idx_i;
  wire tfm_entry_t wr_data_w = scan_wr ? dead_entry : fill_entry_i;

  always_comb begin
    dead_entry       = rd_data;
    dead_entry.valid = 1'b0;
  end

  // ----------------------------------------
  // Entry store
  // ----------------------------------------
  tfm_tlb_mem #(
    .DEPTH (DEPTH),
    .IW    (IW)
  ) u_mem (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .rd_en_i   (rd_en_w),
    .rd_addr_i (idx_reg),
    .rd_data_o (rd_data),
    .wr_en_i   (mem_we_w),
    .wr_addr_i (wr_addr_w),
    .wr_data_i (wr_data_w)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    state_next   = state_reg;
    mode_next    = mode_reg;
    msg_next     = msg_reg;
    idx_next     = idx_reg;
    hit_next     = hit_reg;
    len_req_next = len_req_reg;
    len_sel_next = len_sel_reg;
    wb_next      = wb_reg;
    purge_next   = purge_reg;
    fault_next   = 1'b0;
    susp_next    = 1'b0;
    rebind_next  = 1'b0;
    tstop_next   = 1'b0;
    tstart_next  = 1'b0;
    scan_wr      = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (accept_w) begin
          msg_next = msg_i;
          idx_next = '0;
          hit_next = 1'b0;
          case (msg_i.msg_type)
            `TFM_MSG_FLUSH_PROC: begin
              if (proc_executing_i) begin
                state_next = ST_SUSPEND;
                mode_next  = MODE_PROC;
              end
            end
            `TFM_MSG_FLUSH_ALL: begin
              state_next = ST_SCAN_RD;
              mode_next  = MODE_ALL;
            end
            `TFM_MSG_FLUSH_PTE: begin
              state_next   = ST_LEN_WAIT;
              len_req_next = 1'b1;
              len_sel_next = msg_i.field4;
            end
            `TFM_MSG_FLUSH_PHYS: begin
              state_next = ST_SCAN_RD;
              mode_next  = MODE_PHYS;
            end
            default: begin
              state_next = ST_IDLE;
            end
          endcase
        end
      end
      ST_LEN_WAIT: begin
        if (len_ack_i) begin
          len_req_next = 1'b0;
          if (msg_reg.field3 >= len_value_i) begin
            fault_next = 1'b1;
            state_next = ST_IDLE;
          end else begin
            state_next = ST_SCAN_RD;
            mode_next  = MODE_PTE;
          end
        end
      end
      ST_SUSPEND: begin
        susp_next  = 1'b1;
        tstop_next = 1'b1;
        idx_next   = '0;
        state_next = ST_SCAN_RD;
      end
      ST_SCAN_RD: begin
        state_next = ST_SCAN_CHK;
      end
      ST_SCAN_CHK: begin
        if (kill_w) begin
          scan_wr = 1'b1;
          if (!rd_data.is_pte && tfm_proc_owned(rd_data)) begin
            hit_next = 1'b1;
          end
        end
        if (!last_w) begin
          idx_next   = idx_reg + IW'(1);
          state_next = ST_SCAN_RD;
        end else if (mode_reg == MODE_PROC) begin
          state_next = ST_REBIND;
        end else if (mode_reg == MODE_PHYS) begin
          wb_next    = 1'b1;
          state_next = ST_LREG_WB;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_REBIND: begin
        rebind_next = 1'b1;
        tstart_next = 1'b1;
        state_next  = ST_IDLE;
      end
      ST_LREG_WB: begin
        if (lreg_wb_done_i) begin
          wb_next    = 1'b0;
          purge_next = 1'b1;
          state_next = ST_LREG_PURGE;
        end
      end
      ST_LREG_PURGE: begin
        if (lreg_purge_done_i) begin
          purge_next = 1'b0;
          // The flush-process step still honours the executing-state gate.
          if (hit_reg && proc_executing_i) begin
            mode_next  = MODE_PROC;
            state_next = ST_SUSPEND;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Nothing is taken until the current message has fully finished.
    ready_next = state_next == ST_IDLE;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg   <= ST_IDLE;
      mode_reg    <= MODE_PROC;
      msg_reg     <= '0;
      idx_reg     <= '0;
      hit_reg     <= 1'b0;
      ready_reg   <= 1'b0;
      len_req_reg <= 1'b0;
      len_sel_reg <= '0;
      fault_reg   <= 1'b0;
      susp_reg    <= 1'b0;
      rebind_reg  <= 1'b0;
      tstop_reg   <= 1'b0;
      tstart_reg  <= 1'b0;
      wb_reg      <= 1'b0;
      purge_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      mode_reg    <= mode_next;
      msg_reg     <= msg_next;
      idx_reg     <= idx_next;
      hit_reg     <= hit_next;
      ready_reg   <= ready_next;
      len_req_reg <= len_req_next;
      len_sel_reg <= len_sel_next;
      fault_reg   <= fault_next;
      susp_reg    <= susp_next;
      rebind_reg  <= rebind_next;
      tstop_reg   <= tstop_next;
      tstart_reg  <= tstart_next;
      wb_reg      <= wb_next;
      purge_reg   <= purge_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign msg_ready_o      = ready_reg;
  assign fill_ready_o     = ready_reg;
  assign len_req_o        = len_req_reg;
  assign len_sel_o        = len_sel_reg;
  assign length_fault_o   = fault_reg;
  assign suspend_o        = susp_reg;
  assign rebind_o         = rebind_reg;
  assign timing_stop_o    = tstop_reg;
  assign timing_start_o   = tstart_reg;
  assign lreg_wb_req_o    = wb_reg;
  assign lreg_purge_req_o = purge_reg;

endmodule

// [bench/tfm_handler_checker.sv]
`timescale 1ns/1ps
`include "tfm_defs.svh"
module tfm_handler_checker
  import tfm_pkg::*;
#(
  parameter int DEPTH = `TFM_DEPTH_DEFAULT,
  parameter int IW    = $clog2(`TFM_DEPTH_DEFAULT)
) (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        msg_valid_i,
  input wire tfm_msg_t    msg_i,
  input wire logic        msg_ready_o,
  input wire logic        proc_executing_i,
  input wire logic        len_req_o,
  input wire logic [31:0] len_sel_o,
  input wire logic        len_ack_i,
  input wire logic [31:0] len_value_i,
  input wire logic        length_fault_o,
  input wire logic        suspend_o,
  input wire logic        rebind_o,
  input wire logic        timing_stop_o,
  input wire logic        timing_start_o,
  input wire logic        lreg_wb_req_o,
  input wire logic        lreg_wb_done_i,
  input wire logic        lreg_purge_req_o
);
  logic        take;
  logic        all_reg;
  logic        phys_reg;
  logic [31:0] off_reg;
  int          low_cnt;
  assign take = msg_valid_i && msg_ready_o;
  // The counter measures how long the port stays closed, so scan length is checked exactly.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      all_reg  <= 1'b0;
      phys_reg <= 1'b0;
      off_reg  <= 32'h0000_0000;
      low_cnt  <= 0;
    end else begin
      if (take) begin
        all_reg  <= msg_i.msg_type == `TFM_MSG_FLUSH_ALL;
        phys_reg <= msg_i.msg_type == `TFM_MSG_FLUSH_PHYS;
        off_reg  <= msg_i.field3;
      end
      low_cnt <= msg_ready_o ? 0 : low_cnt + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_take_proc;
    take && msg_i.msg_type == `TFM_MSG_FLUSH_PROC;
  endsequence
  sequence s_len_ack;
    len_req_o && len_ack_i;
  endsequence
  property p_len_select;
    logic [31:0] sel_v;
    (take && msg_i.msg_type == `TFM_MSG_FLUSH_PTE, sel_v = msg_i.field4) |=> len_req_o && len_sel_o == sel_v;
  endproperty
  a_proc_ignored: assert property (s_take_proc ##0 !proc_executing_i |=> (msg_ready_o && !suspend_o) [*2])
    else $error("flush-process acted while not executing");
  a_proc_suspend: assert property (s_take_proc ##0 proc_executing_i |-> ##[1:2] suspend_o)
    else $error("flush-process did not suspend");
  a_timing_pair: assert property (suspend_o == timing_stop_o && rebind_o == timing_start_o)
    else $error("timing stop or start not paired");
  a_rebind_last: assert property (rebind_o |-> msg_ready_o && !$past(msg_ready_o))
    else $error("rebind not at end of operation");
  a_flush_all_len: assert property ($rose(msg_ready_o) && all_reg |-> low_cnt == 2 * DEPTH)
    else $error("flush-whole scan length wrong");
  a_len_select: assert property (p_len_select)
    else $error("length request selector wrong");
  a_len_fault: assert property (s_len_ack ##0 off_reg >= len_value_i |=> length_fault_o && msg_ready_o)
    else $error("length fault missing");
  a_no_fault: assert property (s_len_ack ##0 off_reg < len_value_i |=> !length_fault_o)
    else $error("spurious length fault");
  a_wb_phys: assert property ($rose(lreg_wb_req_o) |-> phys_reg)
    else $error("register write-back outside physical flush");
  a_purge_after: assert property ($rose(lreg_purge_req_o) |-> $past(lreg_wb_done_i) && !lreg_wb_req_o)
    else $error("purge before write-back done");
  a_busy_hold: assert property (len_req_o || lreg_wb_req_o || lreg_purge_req_o || suspend_o |-> !msg_ready_o)
    else $error("port open during operation");
endmodule
bind tfm_handler tfm_handler_checker #(.DEPTH(DEPTH), .IW(IW)) u_tfm_handler_checker (.*);

// [bench/tfm_core_model.sv]
`timescale 1ns/1ps
module tfm_core_model (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        len_req_i,
  input  wire logic [31:0] seg_len_i,
  output logic             len_ack_o,
  output logic [31:0]      len_value_o,
  input  wire logic        wb_req_i,
  output logic             wb_done_o,
  input  wire logic        purge_req_i,
  output logic             purge_done_o
);
  logic [1:0] wait_reg;
  logic       ask;
  logic       go;
  assign ask = (len_req_i && !len_ack_o) || (wb_req_i && !wb_done_o) || (purge_req_i && !purge_done_o);
  assign go  = ask && wait_reg == 2'h0;
  // Length data toggles outside the answer so a late sample never sees a stale value.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      len_ack_o    <= 1'b0;
      len_value_o  <= 32'h0000_0000;
      wb_done_o    <= 1'b0;
      purge_done_o <= 1'b0;
      wait_reg     <= 2'h0;
    end else begin
      len_ack_o    <= go && len_req_i;
      len_value_o  <= (go && len_req_i) ? seg_len_i : ~len_value_o;
      wb_done_o    <= go && wb_req_i;
      purge_done_o <= go && purge_req_i;
      if (ask) begin
        wait_reg <= go ? 2'($urandom_range(3, 0)) : wait_reg - 2'h1;
      end
    end
  end
endmodule

// [bench/test_tlb_flush_message_handler.sv]
`timescale 1ns/1ps
`include "tfm_defs.svh"
module test_tlb_flush_message_handler;
  import tfm_pkg::*;
  localparam int          DEPTH = 8;
  localparam int          IW    = 3;
  localparam logic [19:0] PG    = 20'h0_1234;
  logic             clk_i, reset_n_i, msg_valid_i, msg_ready_o, proc_executing_i;
  logic             fill_valid_i, fill_ready_o, len_req_o, len_ack_i, length_fault_o;
  logic             suspend_o, rebind_o, timing_stop_o, timing_start_o;
  logic             lreg_wb_req_o, lreg_wb_done_i, lreg_purge_req_o, lreg_purge_done_i;
  logic [IW-1:0]    fill_idx_i;
  logic [31:0]      len_sel_o, len_value_i, seg_len, off;
  tfm_msg_t         msg_i;
  tfm_entry_t       fill_entry_i;
  int               fail_count, check_count, rb_cnt, sus_cnt, flt_cnt, wb_cnt, pg_cnt, r0, s0, f0;
  tfm_handler #(.DEPTH(DEPTH), .IW(IW)) u_tfm_handler (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .msg_valid_i(msg_valid_i), .msg_i(msg_i), .msg_ready_o(msg_ready_o), .proc_executing_i(proc_executing_i),
    .fill_valid_i(fill_valid_i), .fill_idx_i(fill_idx_i), .fill_entry_i(fill_entry_i),
    .fill_ready_o(fill_ready_o), .len_req_o(len_req_o), .len_sel_o(len_sel_o), .len_ack_i(len_ack_i),
    .len_value_i(len_value_i), .length_fault_o(length_fault_o), .suspend_o(suspend_o), .rebind_o(rebind_o),
    .timing_stop_o(timing_stop_o), .timing_start_o(timing_start_o), .lreg_wb_req_o(lreg_wb_req_o),
    .lreg_wb_done_i(lreg_wb_done_i), .lreg_purge_req_o(lreg_purge_req_o), .lreg_purge_done_i(lreg_purge_done_i));
  tfm_core_model u_tfm_core_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .len_req_i(len_req_o),
    .seg_len_i(seg_len), .len_ack_o(len_ack_i), .len_value_o(len_value_i), .wb_req_i(lreg_wb_req_o),
    .wb_done_o(lreg_wb_done_i), .purge_req_i(lreg_purge_req_o), .purge_done_o(lreg_purge_done_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    rb_cnt  <= rb_cnt + int'(rebind_o);
    sus_cnt <= sus_cnt + int'(suspend_o);
    flt_cnt <= flt_cnt + int'(length_fault_o);
    wb_cnt  <= wb_cnt + int'(lreg_wb_req_o && lreg_wb_done_i);
    pg_cnt  <= pg_cnt + int'(lreg_purge_req_o && lreg_purge_done_i);
  end
  task automatic stop_test();
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (msg_ready_o !== 1'b1 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 2000) begin
      check("ready_wait", 32'h0000_0001, 32'h0000_0000);
      stop_test();
    end
  endtask
  // Unused fields carry random data so a design that reads them is caught.
  task automatic send(logic [7:0] t, logic [31:0] f3);
    wait_ready();
    msg_i = '{t, $urandom, $urandom, f3, $urandom, $urandom};
    msg_valid_i = 1'b1;
    @(negedge clk_i);
    msg_valid_i = 1'b0;
    msg_i = ~msg_i;
    @(negedge clk_i);
    wait_ready();
    // Closing pulses rise together with ready, so one more cycle lets the counters see them.
    @(negedge clk_i);
  endtask
  task automatic fill(int i, tfm_entry_t e);
    wait_ready();
    check("fill_ready", 32'(fill_ready_o), 32'h0000_0001);
    fill_idx_i = IW'(i);
    fill_entry_i = e;
    fill_valid_i = 1'b1;
    @(negedge clk_i);
    fill_valid_i = 1'b0;
    @(negedge clk_i);
  endtask
  function automatic logic [19:0] rp();
    return 20'h8_0000 | 20'($urandom);
  endfunction
  function automatic tfm_entry_t ent(logic [2:0] own, logic [1:0] pg, logic [19:0] pp, logic [19:0] tp);
    return '{1'b1, 1'b0, own, pg, 1'b0, $urandom, rp(), pp, tp};
  endfunction
  task automatic phys(logic [31:0] exp);
    int r, w, p;
    r = rb_cnt;
    w = wb_cnt;
    p = pg_cnt;
    send(`TFM_MSG_FLUSH_PHYS, {PG, 12'h000});
    check("phys_rebind", 32'(rb_cnt - r), exp);
    check("phys_writeback", 32'(wb_cnt - w), 32'h0000_0001);
    check("phys_purge", 32'(pg_cnt - p), 32'h0000_0001);
  endtask
  initial begin
    void'($urandom(32'h8e4d8332));
    {reset_n_i, msg_valid_i, proc_executing_i, fill_valid_i, fill_idx_i} = '0;
    {msg_i, fill_entry_i, seg_len} = '0;
    {fail_count, check_count, rb_cnt, sus_cnt, flt_cnt, wb_cnt, pg_cnt} = '0;
    repeat (4) @(negedge clk_i);
    reset_n_i = 1'b1;
    for (int i = 0; i < DEPTH; i++) fill(i, ent(`TFM_OWN_OTHER, `TFM_PAGING_SIMPLE, rp(), rp()));
    s0 = sus_cnt;
    send(`TFM_MSG_FLUSH_PROC, $urandom);
    check("idle_proc_suspend", 32'(sus_cnt - s0), 32'h0000_0000);
    proc_executing_i = 1'b1;
    fill(0, ent(`TFM_OWN_PCB, `TFM_PAGING_SIMPLE, PG, rp()));
    phys(32'h0000_0001);
    phys(32'h0000_0000);
    fill(1, ent(`TFM_OWN_REGION1, `TFM_PAGING_SIMPLE, rp(), PG));
    phys(32'h0000_0000);
    fill(1, ent(`TFM_OWN_REGION1, `TFM_PAGING_PAGED, rp(), PG));
    phys(32'h0000_0001);
    fill(1, ent(`TFM_OWN_REGION2, `TFM_PAGING_BIPAGED, rp(), PG));
    phys(32'h0000_0001);
    for (int k = 3; k <= 6; k++) begin
      fill(2, ent(3'(k), `TFM_PAGING_SIMPLE, PG, rp()));
      send(`TFM_MSG_FLUSH_ALL, $urandom);
      phys(32'h0000_0001);
    end
    fill(3, ent(`TFM_OWN_REGION0, `TFM_PAGING_SIMPLE, PG, rp()));
    r0 = rb_cnt;
    s0 = sus_cnt;
    send(`TFM_MSG_FLUSH_PROC, $urandom);
    check("proc_suspend", 32'(sus_cnt - s0), 32'h0000_0001);
    check("proc_rebind", 32'(rb_cnt - r0), 32'h0000_0001);
    phys(32'h0000_0000);
    fill(3, ent(`TFM_OWN_PCB, `TFM_PAGING_SIMPLE, PG, rp()));
    proc_executing_i = 1'b0;
    phys(32'h0000_0000);
    proc_executing_i = 1'b1;
    // Offsets stay region offsets with the top two bits clear; directory entries are never targeted.
    for (int i = 0; i < 12; i++) begin
      seg_len = $urandom_range(32'h0000_4000, 32'h0000_0010);
      off = (i == 0) ? seg_len : (i == 1) ? seg_len - 32'h1 : $urandom_range(2 * seg_len, 0);
      f0 = flt_cnt;
      send(`TFM_MSG_FLUSH_PTE, off & 32'h3FFF_FFFF);
      check("length_fault", 32'(flt_cnt - f0), 32'(off >= seg_len));
    end
    stop_test();
  end
endmodule
